//--- logic/pps_consts.svh
`ifndef PPS_CONSTS_SVH
`define PPS_CONSTS_SVH

// Counts of shared pins in each group
`define PPS_NUM_TIMERS 2
`define PPS_NUM_UARTS 3
`define PPS_NUM_REGION_SEL 7

// Reset value of every peripheral output enable: port operation
`define PPS_ENABLE_RESET 1'h0
// Reset value of the clock output pin synchroniser flops
`define PPS_PIN_RESET 1'h0

`endif

//--- logic/pps_pkg.sv
`include "pps_consts.svh"

package pps_pkg;

  // One bidirectional pad seen from the core: level out and output enable
  typedef struct packed {
    logic out;
    logic oe;
  } pps_pad_drive_t;

  // Port-logic request for one pin
  typedef struct packed {
    logic data;
    logic dir_out;
  } pps_port_req_t;

  // Per-UART peripheral side
  typedef struct packed {
    logic tx_data;
    logic tx_en;
    logic clk_out;
    logic clk_out_en;
  } pps_uart_out_t;

  typedef struct packed {
    logic rx;
    logic clk_in;
  } pps_uart_in_t;

endpackage

//--- logic/pps_pin_share.sv
`include "pps_consts.svh"

module pps_pin_share
  import pps_pkg::*;
#(
  parameter int NT = `PPS_NUM_TIMERS,
  parameter int NU = `PPS_NUM_UARTS,
  parameter int NR = `PPS_NUM_REGION_SEL
) (
  input wire logic core_clk, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic standby_request_n, // Standby pin
  output logic standby_req, // Synchronised standby request
  input wire logic [NT-1:0] timer_wave_out, // Timer waveforms
  input wire logic [NT-1:0] timer_out_en_set, // Timer output enables
  input wire pps_port_req_t [NT-1:0] port_bits_timer_out, // Port requests
  input wire logic [NT-1:0] timer_pin_in, // Timer pad levels
  output pps_pad_drive_t [NT-1:0] timer_pad, // Timer pad drive
  output logic [NT-1:0] timer_port_in, // Timer pins to port
  input wire pps_uart_out_t [NU-1:0] uart_out, // UART outputs
  output pps_uart_in_t [NU-1:0] uart_in, // UART sampled inputs
  input wire pps_port_req_t [NU-1:0] port_rx, // Port on rx pins
  input wire pps_port_req_t [NU-1:0] port_tx, // Port on tx pins
  input wire pps_port_req_t [NU-1:0] port_sck, // Port on clock pins
  input wire logic [NU-1:0] serial_rx_pin, // Receive pad levels
  input wire logic [NU-1:0] serial_tx_pin, // Transmit pad levels
  input wire logic [NU-1:0] serial_clk_pin, // Clock pad levels
  output pps_pad_drive_t [NU-1:0] serial_rx_pad, // Receive pad drive
  output pps_pad_drive_t [NU-1:0] serial_tx_pad, // Transmit pad drive
  output pps_pad_drive_t [NU-1:0] serial_clk_pad, // Clock pad drive
  output logic [NU-1:0] port_rx_in, // Receive pins to port
  output logic [NU-1:0] port_tx_in, // Transmit pins to port
  output logic [NU-1:0] port_sck_in, // Clock pins to port
  input wire logic program_sel, // Program memory select request
  output logic program_mem_select, // Program memory select pin
  input wire logic [NR-1:0] region_sel, // Region select requests
  input wire logic [NR-1:0] region_sel_en, // Chip-select control bits
  input wire pps_port_req_t [NR-1:0] port_bits_select, // Port requests
  input wire logic [NR-1:0] region_pin_in, // Region pad levels
  output pps_pad_drive_t [NR-1:0] region_selects, // Region pad drive
  output logic [NR-1:0] region_port_in, // Region pins to port
  input wire logic clk_out_en_set, // Clock output enable
  input wire logic internal_clk, // Internal clock to present
  input wire pps_port_req_t port_bit_clkout, // Port request on clock pin
  input wire logic clkout_pin_in, // Clock output pad level
  output pps_pad_drive_t clkout_pad, // Clock output pad drive
  output logic clkout_port_in // Clock output pin to port
);

  // Pin mux: peripheral wins while enabled, else the port drives
  function automatic pps_pad_drive_t mux_pin(input logic en,
      input logic per, input pps_port_req_t prt);
    pps_pad_drive_t d;
    d.out = en ? per : prt.data;
    d.oe = en ? 1'h1 : prt.dir_out;
    return d;
  endfunction

  // Enables are registered so every pin with a port request leaves reset as a port bit
  logic [NT-1:0] timer_en;
  logic [NU-1:0] tx_en;
  logic [NU-1:0] sck_en;
  logic [NR-1:0] region_en;
  logic clk_en;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      timer_en <= {NT{`PPS_ENABLE_RESET}};
    end else begin
      timer_en <= timer_out_en_set;
    end
  end

  // Both output enables of a channel move on the same edge
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tx_en <= {NU{`PPS_ENABLE_RESET}};
      sck_en <= {NU{`PPS_ENABLE_RESET}};
    end else begin
      for (int i = 0; i < NU; i++) begin
        tx_en[i] <= uart_out[i].tx_en;
        sck_en[i] <= uart_out[i].clk_out_en;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      region_en <= {NR{`PPS_ENABLE_RESET}};
    end else begin
      region_en <= region_sel_en;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      clk_en <= `PPS_ENABLE_RESET;
    end else begin
      clk_en <= clk_out_en_set;
    end
  end

  // Standby pin is a pure input, synchronised before use
  logic stby_meta;
  logic stby_sync;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stby_meta <= 1'h1;
      stby_sync <= 1'h1;
    end else begin
      stby_meta <= standby_request_n;
      stby_sync <= stby_meta;
    end
  end
  assign standby_req = !stby_sync;

  // Two-flop synchronisers, one per pin group; pad levels are asynchronous
  logic [NT-1:0] tmr_m, tmr_s;
  logic [NU-1:0] rx_m, rx_s, tx_m, tx_s, ck_m, ck_s;
  logic [NR-1:0] rg_m, rg_s;
  logic co_m, co_s;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tmr_m <= '0;
      tmr_s <= '0;
    end else begin
      tmr_m <= timer_pin_in;
      tmr_s <= tmr_m;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rx_m <= '0;
      rx_s <= '0;
    end else begin
      rx_m <= serial_rx_pin;
      rx_s <= rx_m;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tx_m <= '0;
      tx_s <= '0;
    end else begin
      tx_m <= serial_tx_pin;
      tx_s <= tx_m;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ck_m <= '0;
      ck_s <= '0;
    end else begin
      ck_m <= serial_clk_pin;
      ck_s <= ck_m;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rg_m <= '0;
      rg_s <= '0;
    end else begin
      rg_m <= region_pin_in;
      rg_s <= rg_m;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      co_m <= `PPS_PIN_RESET;
      co_s <= `PPS_PIN_RESET;
    end else begin
      co_m <= clkout_pin_in;
      co_s <= co_m;
    end
  end

  // Pins read back to the port in every configuration
  assign timer_port_in = tmr_s;
  assign port_rx_in = rx_s;
  assign port_tx_in = tx_s;
  assign port_sck_in = ck_s;
  assign region_port_in = rg_s;
  assign clkout_port_in = co_s;

  genvar g;
  generate
    for (g = 0; g < NT; g++) begin : g_tmr
      assign timer_pad[g] = mux_pin(timer_en[g], timer_wave_out[g],
                                    port_bits_timer_out[g]);
    end
    for (g = 0; g < NU; g++) begin : g_uart
      // Receive pin has no select; only the port may drive it
      assign serial_rx_pad[g] = mux_pin(1'h0, 1'h0, port_rx[g]);
      assign uart_in[g].rx = rx_s[g];
      assign serial_tx_pad[g] = mux_pin(tx_en[g], uart_out[g].tx_data,
                                        port_tx[g]);
      assign serial_clk_pad[g] = mux_pin(sck_en[g], uart_out[g].clk_out,
                                         port_sck[g]);
      // Clock input seen regardless of who drives the pad
      assign uart_in[g].clk_in = ck_s[g];
    end
    for (g = 0; g < NR; g++) begin : g_reg
      assign region_selects[g] = mux_pin(region_en[g], region_sel[g],
                                         port_bits_select[g]);
    end
  endgenerate

  // Program select registered so the pin comes from a flip-flop
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      program_mem_select <= 1'h1;
    end else begin
      program_mem_select <= program_sel;
    end
  end

  // Clock passes straight through; registering it would halve its rate
  assign clkout_pad = mux_pin(clk_en, internal_clk, port_bit_clkout);

endmodule

//--- verification/pps_pin_share_assertions.sv
`include "pps_consts.svh"
module pps_pin_share_assertions
  import pps_pkg::*;
#(parameter int NU = `PPS_NUM_UARTS) (
  input logic core_clk, // Clock
  input logic resetn, // Reset
  input logic standby_request_n, // Pin
  input logic standby_req, // Synced
  input pps_uart_out_t [NU-1:0] uart_out, // UART
  input pps_uart_in_t [NU-1:0] uart_in, // UART
  input pps_port_req_t [NU-1:0] port_rx, // Port
  input pps_port_req_t [NU-1:0] port_tx, // Port
  input pps_port_req_t [NU-1:0] port_sck, // Port
  input pps_pad_drive_t [NU-1:0] serial_rx_pad, // Pad
  input pps_pad_drive_t [NU-1:0] serial_tx_pad, // Pad
  input pps_pad_drive_t [NU-1:0] serial_clk_pad, // Pad
  input logic [NU-1:0] serial_rx_pin, // Pin
  input logic [NU-1:0] serial_clk_pin // Pin
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int L = NU - 1;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Enables are registered, so a pad trails its enable by one edge
  sequence s_run; resetn [*2]; endsequence
  // Pad levels pass two flops before the core sees them
  sequence s_sync; resetn [*3]; endsequence
  a_tx_first: assert property (s_run |-> serial_tx_pad[0] ==
    ($past(uart_out[0].tx_en) ? {uart_out[0].tx_data, 1'h1} : port_tx[0]))
    else $error("tx pad 0");
  a_tx_last: assert property (s_run |-> serial_tx_pad[L] ==
    ($past(uart_out[L].tx_en) ? {uart_out[L].tx_data, 1'h1} : port_tx[L]))
    else $error("tx pad last");
  a_clk_first: assert property (s_run |-> serial_clk_pad[0] == (
    $past(uart_out[0].clk_out_en) ? {uart_out[0].clk_out, 1'h1} :
    port_sck[0])) else $error("clk pad 0");
  a_clk_last: assert property (s_run |-> serial_clk_pad[L] == (
    $past(uart_out[L].clk_out_en) ? {uart_out[L].clk_out, 1'h1} :
    port_sck[L])) else $error("clk pad last");
  a_rx_port_only: assert property (serial_rx_pad[L] == port_rx[L])
    else $error("rx pad");
  a_rx_sampled: assert property (s_sync |->
    uart_in[0].rx == $past(serial_rx_pin[0], 2)) else $error("rx sync");
  a_clk_sampled: assert property (s_sync |->
    uart_in[L].clk_in == $past(serial_clk_pin[L], 2)) else $error("clk in");
  a_standby_sync: assert property (s_sync |->
    standby_req == !$past(standby_request_n, 2)) else $error("standby");
endmodule

//--- verification/pps_board.sv
module pps_board #(parameter int W = 1) (
  input logic [2*W-1:0] pad, // Pad drive pairs
  input logic [W-1:0] ext, // Board level
  output logic [W-1:0] pin // Wire level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Board parts always drive, so a pin the chip leaves never floats
  always_comb begin
    for (int k = 0; k < W; k++) begin
      pin[k] = pad[2*k] ? pad[2*k+1] : ext[k];
    end
  end
endmodule

//--- verification/peripheral_pin_sharing_tb_top.sv
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module peripheral_pin_sharing_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pps_pkg::*;
  logic core_clk, resetn, standby_request_n, standby_req, program_sel, d;
  logic program_mem_select, clk_out_en_set, internal_clk, clkout_port_in;
  logic [1:0] timer_wave_out, timer_out_en_set, timer_port_in;
  logic [2:0] port_rx_in, port_tx_in, port_sck_in;
  logic [6:0] region_sel, region_sel_en, region_port_in;
  logic [18:0] en, ext;
  logic [18:0] tbl [5] = '{19'h0, 19'h7FFFF, 19'h2AAAA, 19'h55555, 19'h1C};
  pps_port_req_t p, port_bit_clkout;
  pps_port_req_t [1:0] port_bits_timer_out;
  pps_port_req_t [2:0] port_rx, port_tx, port_sck;
  pps_port_req_t [6:0] port_bits_select;
  pps_pad_drive_t clkout_pad;
  pps_pad_drive_t [1:0] timer_pad;
  pps_pad_drive_t [2:0] serial_rx_pad, serial_tx_pad, serial_clk_pad;
  pps_pad_drive_t [6:0] region_selects;
  pps_uart_out_t [2:0] uart_out;
  pps_uart_in_t [2:0] uart_in;
  wire [1:0] timer_pin_in;
  wire [2:0] serial_rx_pin, serial_tx_pin, serial_clk_pin;
  wire [6:0] region_pin_in;
  wire clkout_pin_in;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  wire [37:0] pads = {clkout_pad, region_selects, serial_clk_pad,
    serial_tx_pad, serial_rx_pad, timer_pad};
  wire [18:0] seen = {clkout_port_in, region_port_in, port_sck_in,
    port_tx_in, port_rx_in, timer_port_in};
  assign {clk_out_en_set, region_sel_en, timer_out_en_set} =
    {en[18:11], en[1:0]};
  assign {timer_wave_out, region_sel, internal_clk} = {10{d}};
  assign {port_bits_timer_out, port_rx, port_tx, port_sck, port_bits_select,
    port_bit_clkout} = {19{p}};
  always_comb begin
    for (int u = 0; u < 3; u++) begin
      uart_out[u] = {d, en[5+u], d, en[8+u]};
    end
  end
  pps_pin_share uut (.*);
  pps_board #(.W(19)) board (.pad(pads), .ext(ext), .pin({clkout_pin_in,
    region_pin_in, serial_clk_pin, serial_tx_pin, serial_rx_pin,
    timer_pin_in}));
  // Receive pins (bits 2 to 4) have no enable and stay with the port
  function automatic logic [37:0] exp_pads(logic [18:0] e, logic dv,
    logic [1:0] pv);
    for (int k = 0; k < 19; k++) begin
      exp_pads[2*k +: 2] = (e[k] && (k < 2 || k > 4)) ? {dv, 1'h1} : pv;
    end
  endfunction
  task automatic step(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    resetn = 1'h0;
    standby_request_n = 1'h1;
    program_sel = 1'h1;
    d = 1'h0;
    ext = 19'h0;
    // Every enable requested during reset: none may reach a pad
    en = 19'h7FFFF;
    p = 2'h3;
    step(12);
    `CHK("reset pads", exp_pads(19'h0, 1'h0, 2'h3), pads)
    `CHK("reset cs", 1'h1, program_mem_select)
    `CHK("reset standby", 1'h0, standby_req)
    `CHK("reset pins", 19'h0, seen)
    $display("reset test done");
    resetn = 1'h1;
    foreach (tbl[i]) begin
      for (int j = 0; j < 2; j++) begin
        en = tbl[i];
        d = j[0];
        p = j ? 2'h0 : 2'h3;
        step(1);
        `CHK("pads", exp_pads(tbl[i], j[0], p), pads)
      end
    end
    $display("pad select test done");
    en = 19'h0;
    p = 2'h0;
    program_sel = 0;
    step(3);
    ext = 19'h7FFFF;
    standby_request_n = 0;
    step(1);
    `CHK("early pins", 19'h0, seen)
    step(1);
    `CHK("pins", 19'h7FFFF, seen)
    `CHK("uart in", 6'h3F, uart_in)
    `CHK("standby", 1'h1, standby_req)
    `CHK("cs", 1'h0, program_mem_select)
    $display("input sync test done");
    en = 19'h7FFFF;
    step(1);
    resetn = 0;
    step(1);
    `CHK("mid reset pads", exp_pads(19'h0, 1'h0, 2'h0), pads)
    `CHK("mid reset standby", 1'h0, standby_req)
    resetn = 1'h1;
    step(1);
    `CHK("release pads", exp_pads(19'h7FFFF, d, p), pads)
    `CHK("release standby", 1'h0, standby_req)
    step(1);
    `CHK("synced standby", 1'h1, standby_req)
    step(1);
    $display("second reset test done");
    final_report();
  end
endmodule
bind pps_pin_share pps_pin_share_assertions #(.NU(NU)) chk (.*);
